// ---- verilog/cgu_params.svh ----
// constants of the clock generation unit: codes, field positions, counts
// assumes a 40 MHz system clock; oscillators arrive as one-cycle ticks
// How it works
// RULE1: a machine cycle spans exactly two CPU clock periods
// RULE2: oscillator clock comes from one of four configured sources
// RULE3: peripheral clock runs at half the CPU clock
// RULE4: RC oscillator is 7.373 MHz, 14.746 MHz with doubler on
// RULE5: crystal has low, medium and high ranges; feeds clock, RTC, watchdog
// RULE6: clock output drives only when enabled and nobody uses the crystal
// RULE7: clock output toggles once per CPU clock, so it runs at half the CPU clock rate
// RULE8: software should clear clock output enable before Idle to save power
// RULE9: six-bit RC tuning field, factory loaded at reset, writable later
// RULE10: tuning reloads only on power-on or watchdog reset
// RULE11: low-power select clears on reset; software sets it only at 8 MHz or less
// RULE12: CPU clock never exceeds 18 MHz
// RULE13: configuration must enable brownout trips for doubler or fast external clock
// RULE14: external clock input accepts static up to 18 MHz
// RULE15: on-the-fly switching; switch-done clears at start, sets at end
// RULE16: control writes ignored while switch-done is zero
// RULE17: reset loads source select from config byte one, doubler from two
// RULE18: crystal wake-up holds CPU clock 1024 oscillator cycles plus 60 us
// RULE19: RC wake-up holds CPU clock 200 to 300 us
// RULE20: watchdog or external wake-up holds CPU clock 32 oscillator cycles
// RULE21: programmable divider reaches a largest ratio of 510
// RULE22: divider value N divides by 2N; zero passes undivided
// RULE23: divider may change any time without halting execution
// RULE24: watchdog oscillator nominal 400 kHz, selectable low-power source
`ifndef CGU_PARAMS_SVH
`define CGU_PARAMS_SVH

// ----------------------------------------------------------------------
// source select codes
// ----------------------------------------------------------------------
`define SRC_XTAL_LO     3'h0
`define SRC_XTAL_MED    3'h1
`define SRC_XTAL_HI     3'h2
`define SRC_EXT         3'h3
`define SRC_RC          3'h4
`define SRC_WDT         3'h5

// ----------------------------------------------------------------------
// configuration byte fields
// ----------------------------------------------------------------------
`define CFG1_SRC_LSB    0
`define CFG2_DBL_BIT    7

// ----------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------
`define DIV_RST         8'h00
`define LP_RST          1'b0
`define TRIM_RST        6'h00

// ----------------------------------------------------------------------
// timing
// ----------------------------------------------------------------------
`define CLK_PERIOD_NS   25
`define RC_FREQ_KHZ     7373
`define RC_DBL_FREQ_KHZ 14746
`define WDT_FREQ_KHZ    400
`define LP_MAX_MHZ      8
`define CPU_MAX_MHZ     18
`define MC_CPU_CLKS     2
`define XTAL_WAKE_OSC   11'd1024
`define SLOW_WAKE_OSC   11'd32
`define NO_WAKE_OSC     11'd0
`define XTAL_EXTRA_NS   60000
`define RC_WAKE_NS      200000
`define XTAL_EXTRA_CYC  ((`XTAL_EXTRA_NS+`CLK_PERIOD_NS-1)/`CLK_PERIOD_NS)
`define RC_WAKE_CYC     ((`RC_WAKE_NS+`CLK_PERIOD_NS-1)/`CLK_PERIOD_NS)
`define CPU_MIN_GAP     ((1000+`CPU_MAX_MHZ*`CLK_PERIOD_NS-1)/(`CPU_MAX_MHZ*`CLK_PERIOD_NS))

`endif

// ---- verilog/cgu_pkg.sv ----
// types of the clock generation unit
// assumes cgu_params.svh for the numeric constants
package cgu_pkg;

    typedef logic [2:0] src_t;
    typedef logic [5:0] trim_t;
    typedef logic [7:0] div_t;

    typedef enum logic [1:0] {ST_LOAD, ST_WAKE_OSC, ST_WAKE_TIME, ST_RUN}
        cgu_state_t;

    typedef struct packed {
        cgu_state_t  st;
        src_t        src;
        src_t        pend;
        logic        dbl;
        div_t        div;
        logic [8:0]  div_cnt;
        logic [10:0] ocnt;
        logic [13:0] tcnt;
        logic        done;
        logic        hold;
        logic        fire;
        logic [1:0]  gap;
        logic        phase;
        logic        clkout;
        logic        clkout_oe;
        logic        lp;
        logic        ext_prev;
        logic        osc_en;
        logic        cpu_en;
        logic        mc_en;
        logic        pclk_en;
    } cgu_regs_t;

    typedef struct packed {
        logic  loaded;
        trim_t trim;
        logic  clkout_enable;
    } trim_regs_t;

endpackage

// ---- verilog/rc_trim_reg.sv ----
// RC tuning register with clock output enable
// assumes i_trim_arst_n asserts only on power-on and watchdog reset
`timescale 1ns/10ps
`include "cgu_params.svh"
module rc_trim_reg
(
    // clock and reset
    input  wire logic         i_clk,
    input  wire logic         i_trim_arst_n,
    // factory value and software write
    input  wire cgu_pkg::trim_t i_factory_trim,
    input  wire logic         i_wr,
    input  wire cgu_pkg::trim_t i_trim,
    input  wire logic         i_clkout_en,
    // register contents
    output cgu_pkg::trim_t    o_trim,
    output logic              o_clkout_enable
);
    import cgu_pkg::*;

    trim_regs_t s_q;
    trim_regs_t s_d;

    always_comb
    begin
        s_d = s_q;
        if (!s_q.loaded)
        begin
            s_d.loaded = 1'b1;
            s_d.trim   = i_factory_trim; // RULE9 RULE10
        end
        else if (i_wr)
        begin
            s_d.trim  = i_trim; // RULE9
            s_d.clkout_enable = i_clkout_en;
        end
    end

    always_ff @(posedge i_clk or negedge i_trim_arst_n)
    begin
        if (!i_trim_arst_n)
            s_q <= '{loaded: 1'b0, trim: `TRIM_RST, clkout_enable: 1'b0}; // RULE10
        else
            s_q <= s_d;
    end

    assign o_trim          = s_q.trim;
    assign o_clkout_enable = s_q.clkout_enable;

endmodule // rc_trim_reg

// ---- verilog/clock_gen_unit.sv ----
// clock generation unit: source select, wake-up, divider, clock output
// assumes oscillators arrive as one-cycle ticks synchronous to i_clk
`timescale 1ns/10ps
`include "cgu_params.svh"
module clock_gen_unit
#(
    parameter int unsigned RC_WAKE_CYC = `RC_WAKE_CYC
)
(
    // clock and resets
    input  wire logic           i_clk,
    input  wire logic           i_arst_n,
    input  wire logic           i_trim_arst_n,
    // nonvolatile configuration
    input  wire logic [7:0]     i_user_config_byte_one,
    input  wire logic [7:0]     i_user_config_byte_two,
    input  wire cgu_pkg::trim_t i_factory_trim,
    // oscillator ticks and external clock level
    input  wire logic           i_xtal_tick,
    input  wire logic           i_rc_tick,
    input  wire logic           i_wdt_tick,
    input  wire logic           i_osc_in_pin,
    // other crystal consumers
    input  wire logic           i_rtc_uses_xtal,
    input  wire logic           i_wdt_uses_xtal,
    // clock control register write
    input  wire logic           i_ctl_wr,
    input  wire cgu_pkg::src_t  i_ctl_src,
    input  wire logic           i_ctl_dbl,
    // divider write
    input  wire logic           i_div_wr,
    input  wire cgu_pkg::div_t  i_div_val,
    // tuning register write
    input  wire logic           i_trim_wr,
    input  wire cgu_pkg::trim_t i_trim_val,
    input  wire logic           i_clkout_en_val,
    // low-power select write
    input  wire logic           i_lp_wr,
    input  wire logic           i_lp_val,
    // clock enables
    output logic                o_osc_clock_en,
    output logic                o_cpu_core_clock_en,
    output logic                o_periph_clk_en,
    output logic                o_machine_cycle_en,
    output logic                o_cpu_hold,
    // status and control read-back
    output logic                o_clock_switch_done,
    output cgu_pkg::src_t       o_clock_source_select,
    output logic                o_rc_doubler_enable,
    output cgu_pkg::div_t       o_cpu_clock_divider,
    output logic                o_low_power_clock_select,
    output cgu_pkg::trim_t      o_rc_trim,
    output logic                o_clkout_enable,
    // clock output pin
    output logic                o_clkout_pin_o,
    output logic                o_clkout_pin_oe
);
    import cgu_pkg::*;

    localparam logic [13:0] XTAL_EXTRA = 14'(`XTAL_EXTRA_CYC);
    localparam logic [13:0] RC_WAKE    = 14'(RC_WAKE_CYC);
    localparam logic [1:0]  GAP_MIN    = 2'(`CPU_MIN_GAP - 1);

    cgu_regs_t s_q;
    cgu_regs_t s_d;
    logic      ext_tick;
    logic      osc_tick;
    logic      pend_tick;
    logic      clkout_en;
    logic [8:0] div_top;

    // ------------------------------------------------------------------
    // tuning register
    // ------------------------------------------------------------------
    rc_trim_reg rc_trim_reg_inst
    (
        .i_clk           (i_clk),
        .i_trim_arst_n   (i_trim_arst_n),
        .i_factory_trim  (i_factory_trim),
        .i_wr            (i_trim_wr),
        .i_trim          (i_trim_val),
        .i_clkout_en     (i_clkout_en_val),
        .o_trim          (o_rc_trim),
        .o_clkout_enable (clkout_en)
    );

    // ------------------------------------------------------------------
    // source helpers
    // ------------------------------------------------------------------
    function automatic logic is_xtal(src_t s);
        return (s == `SRC_XTAL_LO) || (s == `SRC_XTAL_MED) ||
               (s == `SRC_XTAL_HI);
    endfunction

    // tick of a source; unused codes fall back to the RC oscillator
    function automatic logic src_tick(src_t s, logic xt, logic ex,
                                      logic rc, logic wd);
        logic t;
        t = rc;
        if (is_xtal(s))
            t = xt;
        else if (s == `SRC_EXT)
            t = ex;
        else if (s == `SRC_WDT)
            t = wd; // RULE24
        return t;
    endfunction

    // oscillator cycles to wait before the clock is trusted
    function automatic logic [10:0] osc_need(src_t s);
        logic [10:0] n;
        n = `NO_WAKE_OSC;
        if (is_xtal(s))
            n = `XTAL_WAKE_OSC; // RULE18
        else if ((s == `SRC_EXT) || (s == `SRC_WDT))
            n = `SLOW_WAKE_OSC; // RULE20
        return n;
    endfunction

    // system cycles to wait after the oscillator count
    function automatic logic [13:0] time_need(src_t s);
        logic [13:0] n;
        n = 14'h0000;
        if (is_xtal(s))
            n = XTAL_EXTRA; // RULE18
        else if ((s != `SRC_EXT) && (s != `SRC_WDT))
            n = RC_WAKE; // RULE19
        return n;
    endfunction

    assign ext_tick  = i_osc_in_pin & ~s_q.ext_prev; // RULE14
    assign osc_tick  = src_tick(s_q.src, i_xtal_tick, ext_tick,
                                i_rc_tick, i_wdt_tick); // RULE2
    assign pend_tick = src_tick(s_q.pend, i_xtal_tick, ext_tick,
                                i_rc_tick, i_wdt_tick);
    assign div_top   = {s_q.div, 1'b0} - 9'h001;

    // ------------------------------------------------------------------
    // next state
    // ------------------------------------------------------------------
    always_comb
    begin
        s_d          = s_q;
        s_d.ext_prev = i_osc_in_pin;
        s_d.osc_en   = osc_tick & ~s_q.hold;
        s_d.cpu_en   = 1'b0;
        s_d.mc_en    = 1'b0;
        s_d.pclk_en  = 1'b0;
        if (s_q.gap != 2'h3)
            s_d.gap = s_q.gap + 2'h1;

        unique case (s_q.st)
            ST_LOAD:
            begin
                s_d.src  = i_user_config_byte_one[`CFG1_SRC_LSB +: 3]; // RULE17
                s_d.pend = i_user_config_byte_one[`CFG1_SRC_LSB +: 3]; // RULE17
                s_d.dbl  = i_user_config_byte_two[`CFG2_DBL_BIT]; // RULE17
                s_d.ocnt = 11'h000;
                s_d.st   = ST_WAKE_OSC;
            end
            ST_WAKE_OSC:
            begin
                if (s_q.ocnt >= osc_need(s_q.pend))
                begin
                    s_d.tcnt = 14'h0000;
                    s_d.st   = ST_WAKE_TIME;
                end
                else if (pend_tick)
                    s_d.ocnt = s_q.ocnt + 11'h001; // RULE18 RULE20
            end
            ST_WAKE_TIME:
            begin
                if (s_q.tcnt >= time_need(s_q.pend))
                begin
                    s_d.src  = s_q.pend;
                    s_d.done = 1'b1; // RULE15
                    s_d.hold = 1'b0; // RULE19
                    s_d.div_cnt = 9'h000;
                    s_d.st   = ST_RUN;
                end
                else
                    s_d.tcnt = s_q.tcnt + 14'h0001;
            end
            ST_RUN:
            begin
                if (i_ctl_wr && s_q.done) // RULE16
                begin
                    s_d.dbl = i_ctl_dbl; // RULE4
                    if (i_ctl_src != s_q.src)
                    begin
                        s_d.pend = i_ctl_src;
                        s_d.done = 1'b0; // RULE15
                        s_d.ocnt = 11'h000;
                        s_d.st   = ST_WAKE_OSC;
                    end
                end
            end
        endcase

        // divider by 2N, zero passes through
        if (i_div_wr)
            s_d.div = i_div_val; // RULE23
        if (osc_tick && !s_q.hold)
        begin
            if ((s_q.div == 8'h00) || (s_q.div_cnt >= div_top)) // RULE22
            begin
                s_d.div_cnt = 9'h000;
                s_d.fire    = 1'b1; // RULE21
            end
            else
                s_d.div_cnt = s_q.div_cnt + 9'h001;
        end

        // CPU enable, spaced to cap the rate
        if ((s_q.fire || (osc_tick && !s_q.hold && s_d.fire)) &&
            (s_q.gap >= GAP_MIN)) // RULE12
        begin
            s_d.fire    = 1'b0;
            s_d.gap     = 2'h0;
            s_d.cpu_en  = 1'b1;
            s_d.phase   = ~s_q.phase;
            s_d.mc_en   = s_q.phase; // RULE1
            s_d.pclk_en = s_q.phase; // RULE3
            s_d.clkout  = ~s_q.clkout; // RULE7
        end

        s_d.clkout_oe = clkout_en && !is_xtal(s_q.src) &&
                        !i_rtc_uses_xtal && !i_wdt_uses_xtal; // RULE6 RULE5

        if (i_lp_wr)
            s_d.lp = i_lp_val; // RULE11
    end

    // ------------------------------------------------------------------
    // state register
    // ------------------------------------------------------------------
    always_ff @(posedge i_clk or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            s_q           <= '0;
            s_q.st        <= ST_LOAD;
            s_q.src       <= `SRC_RC;
            s_q.pend      <= `SRC_RC;
            s_q.div       <= `DIV_RST;
            s_q.hold      <= 1'b1;
            s_q.lp        <= `LP_RST; // RULE11
        end
        else
            s_q <= s_d;
    end

    // ------------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------------
    assign o_osc_clock_en           = s_q.osc_en;
    assign o_cpu_core_clock_en      = s_q.cpu_en;
    assign o_periph_clk_en          = s_q.pclk_en;
    assign o_machine_cycle_en       = s_q.mc_en;
    assign o_cpu_hold               = s_q.hold;
    assign o_clock_switch_done      = s_q.done;
    assign o_clock_source_select    = s_q.src;
    assign o_rc_doubler_enable      = s_q.dbl;
    assign o_cpu_clock_divider      = s_q.div;
    assign o_low_power_clock_select = s_q.lp;
    assign o_clkout_enable          = clkout_en;
    assign o_clkout_pin_o           = s_q.clkout & s_q.clkout_oe;
    assign o_clkout_pin_oe          = s_q.clkout_oe;

endmodule // clock_gen_unit

// ---- verif/cgu_monitor.sv ----
// concurrent checks on the ports of the clock generation unit
// assumes one clock domain; bound into clock_gen_unit
`timescale 1ns/10ps
module cgu_monitor
#(
    parameter int unsigned RC_WAKE_CYC = 20
)
(
    // clock, reset and requests
    input wire logic           i_clk,
    input wire logic           i_arst_n,
    input wire logic           i_ctl_wr,
    input wire cgu_pkg::src_t  i_ctl_src,
    input wire logic           i_ctl_dbl,
    input wire logic           i_div_wr,
    input wire cgu_pkg::div_t  i_div_val,
    input wire logic           i_lp_wr,
    input wire logic           i_lp_val,
    input wire logic           i_rtc_uses_xtal,
    input wire logic           i_wdt_uses_xtal,
    // design outputs
    input wire logic           o_osc_clock_en,
    input wire logic           o_cpu_core_clock_en,
    input wire logic           o_periph_clk_en,
    input wire logic           o_machine_cycle_en,
    input wire logic           o_cpu_hold,
    input wire logic           o_clock_switch_done,
    input wire cgu_pkg::src_t  o_clock_source_select,
    input wire logic           o_rc_doubler_enable,
    input wire cgu_pkg::div_t  o_cpu_clock_divider,
    input wire logic           o_low_power_clock_select,
    input wire logic           o_clkout_enable,
    input wire logic           o_clkout_pin_o,
    input wire logic           o_clkout_pin_oe
);
    import cgu_pkg::*;
    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (!i_arst_n);
    // ------------------------------------------------------------------
    // properties
    // ------------------------------------------------------------------
    property p_mc;
        o_periph_clk_en == o_machine_cycle_en;
    endproperty
    property p_periph;
        o_periph_clk_en |-> o_cpu_core_clock_en;
    endproperty
    property p_gap;
        o_cpu_core_clock_en |=> !o_cpu_core_clock_en [*2];
    endproperty
    property p_hold;
        o_cpu_hold |-> !o_cpu_core_clock_en && !o_osc_clock_en;
    endproperty
    property p_oe;
        o_clkout_pin_oe |-> $past(o_clkout_enable && !i_rtc_uses_xtal
            && !i_wdt_uses_xtal && o_clock_source_select > 3'h2);
    endproperty
    property p_pin;
        !o_clkout_pin_oe |-> !o_clkout_pin_o;
    endproperty
    property p_sw;
        o_clock_switch_done && i_ctl_wr && i_ctl_src <= 3'h5
            && i_ctl_src != o_clock_source_select |=> !o_clock_switch_done;
    endproperty
    property p_keep;
        !o_clock_switch_done && !o_cpu_hold
            |=> $stable(o_clock_source_select) || o_clock_switch_done;
    endproperty
    property p_dbl;
        o_clock_switch_done && i_ctl_wr
            |=> o_rc_doubler_enable == $past(i_ctl_dbl);
    endproperty
    property p_div;
        i_div_wr |=> o_cpu_clock_divider == $past(i_div_val);
    endproperty
    property p_lp;
        i_lp_wr |=> o_low_power_clock_select == $past(i_lp_val);
    endproperty
    property p_wake;
        $fell(o_clock_switch_done) |-> !o_clock_switch_done [*8];
    endproperty
    // ------------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------------
    a_mc: assert property (p_mc)
        else $error("machine cycle enable differs from peripheral enable");
    a_periph: assert property (p_periph)
        else $error("peripheral enable without cpu enable");
    a_gap: assert property (p_gap)
        else $error("cpu enables closer than three cycles");
    a_hold: assert property (p_hold)
        else $error("clock enable while held");
    a_oe: assert property (p_oe)
        else $error("clock output driven while not allowed");
    a_pin: assert property (p_pin)
        else $error("clock output level high while released");
    a_sw: assert property (p_sw)
        else $error("switch done did not clear on switch");
    a_keep: assert property (p_keep)
        else $error("source changed during switch");
    a_dbl: assert property (p_dbl)
        else $error("doubler write not taken");
    a_div: assert property (p_div)
        else $error("divider write not taken");
    a_lp: assert property (p_lp)
        else $error("low power select write not taken");
    a_wake: assert property (p_wake)
        else $error("switch finished too soon");
    c_out: cover property (o_clkout_pin_oe && o_clkout_pin_o);
    c_sw: cover property ($rose(o_clock_switch_done) && !o_cpu_hold);
    c_pc: cover property (o_periph_clk_en);
endmodule // cgu_monitor

bind clock_gen_unit cgu_monitor #(.RC_WAKE_CYC(RC_WAKE_CYC)) cgu_monitor_inst
(
    .i_clk, .i_arst_n, .i_ctl_wr, .i_ctl_src, .i_ctl_dbl, .i_div_wr,
    .i_div_val, .i_lp_wr, .i_lp_val, .i_rtc_uses_xtal, .i_wdt_uses_xtal,
    .o_osc_clock_en, .o_cpu_core_clock_en, .o_periph_clk_en,
    .o_machine_cycle_en, .o_cpu_hold, .o_clock_switch_done,
    .o_clock_source_select, .o_rc_doubler_enable, .o_cpu_clock_divider,
    .o_low_power_clock_select, .o_clkout_enable, .o_clkout_pin_o,
    .o_clkout_pin_oe
);

// ---- verif/osc_source_model.sv ----
// oscillators outside the unit: crystal, RC, watchdog, external clock
// assumes ticks are taken at the rising edge of the system clock
`timescale 1ns/10ps
module osc_source_model
#(
    parameter int XTAL_PER = 4,
    parameter int WDT_PER  = 100,
    parameter int EXT_PER  = 8
)
(
    input  wire logic i_clk,
    input  wire logic i_dbl,
    output logic      o_xtal_tick,
    output logic      o_rc_tick,
    output logic      o_wdt_tick,
    output logic      o_ext_clk
);
    int n = 0;
    initial {o_xtal_tick, o_rc_tick, o_wdt_tick, o_ext_clk} = 4'h0;
    always @(negedge i_clk)
    begin
        n <= n + 1;
        o_xtal_tick <= (n % XTAL_PER) == 0;
        o_rc_tick <= (n % (i_dbl ? 3 : 5)) == 0;
        o_wdt_tick <= (n % WDT_PER) == 0;
        o_ext_clk <= (n % EXT_PER) < EXT_PER / 2;
    end
endmodule // osc_source_model

// ---- verif/clock_gen_unit_tb_top.sv ----
// self-checking bench for the clock generation unit
// assumes the oscillator model and the bound port monitor
`timescale 1ns/10ps
module clock_gen_unit_tb_top;
    import cgu_pkg::*;
    logic i_clk, i_arst_n, i_trim_arst_n, i_xtal_tick, i_rc_tick;
    logic i_wdt_tick, i_osc_in_pin, i_rtc_uses_xtal, i_wdt_uses_xtal;
    logic [7:0] i_user_config_byte_one, i_user_config_byte_two;
    logic i_ctl_wr, i_ctl_dbl, i_div_wr, i_trim_wr, i_clkout_en_val;
    logic i_lp_wr, i_lp_val, o_osc_clock_en, o_cpu_core_clock_en;
    logic o_periph_clk_en, o_machine_cycle_en, o_cpu_hold;
    logic o_clock_switch_done, o_rc_doubler_enable;
    logic o_low_power_clock_select, o_clkout_enable;
    logic o_clkout_pin_o, o_clkout_pin_oe;
    src_t i_ctl_src, o_clock_source_select;
    div_t i_div_val, o_cpu_clock_divider;
    trim_t i_factory_trim, i_trim_val, o_rc_trim;
    int n_mismatch = 0;
    int n_checks = 0;
    int cyc = 0;
    int nc, np, nt, per;
    logic [7:0] divs [3] = '{8'h00, 8'h02, 8'hff};
    logic [2:0] srcs [3] = '{3'h3, 3'h2, 3'h4};

    clock_gen_unit #(.RC_WAKE_CYC(20)) clock_gen_unit_inst
    (
        .i_clk, .i_arst_n, .i_trim_arst_n, .i_user_config_byte_one,
        .i_user_config_byte_two, .i_factory_trim, .i_xtal_tick,
        .i_rc_tick, .i_wdt_tick, .i_osc_in_pin, .i_rtc_uses_xtal,
        .i_wdt_uses_xtal, .i_ctl_wr, .i_ctl_src, .i_ctl_dbl, .i_div_wr,
        .i_div_val, .i_trim_wr, .i_trim_val, .i_clkout_en_val, .i_lp_wr,
        .i_lp_val, .o_osc_clock_en, .o_cpu_core_clock_en,
        .o_periph_clk_en, .o_machine_cycle_en, .o_cpu_hold,
        .o_clock_switch_done, .o_clock_source_select,
        .o_rc_doubler_enable, .o_cpu_clock_divider,
        .o_low_power_clock_select, .o_rc_trim, .o_clkout_enable,
        .o_clkout_pin_o, .o_clkout_pin_oe
    );
    osc_source_model osc_source_model_inst
    (
        .i_clk, .i_dbl(o_rc_doubler_enable), .o_xtal_tick(i_xtal_tick),
        .o_rc_tick(i_rc_tick), .o_wdt_tick(i_wdt_tick),
        .o_ext_clk(i_osc_in_pin)
    );
    // ------------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------------
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [7:0] s, e);
        n_checks++;
        if (s !== e)
        begin
            n_mismatch++;
            $display("wrong value %s expected %h seen %h", nm, e, s);
        end
    endtask
    // strobes {ctl, div, trim, lp}; fields taken from one byte
    task automatic wr(input logic [3:0] sel, input logic [7:0] v);
        @(negedge i_clk);
        {i_ctl_dbl, i_ctl_src, i_div_val} = {v[3], v[2:0], v};
        {i_clkout_en_val, i_trim_val, i_lp_val} = {v[6], v[5:0], v[0]};
        {i_ctl_wr, i_div_wr, i_trim_wr, i_lp_wr} = sel;
        @(negedge i_clk);
        {i_ctl_wr, i_div_wr, i_trim_wr, i_lp_wr} = 4'h0;
    endtask
    task automatic wait_done(input int lim);
        repeat (lim)
            if (o_clock_switch_done !== 1'b1)
                @(negedge i_clk);
        chk("done", 8'(o_clock_switch_done), 8'h01);
    endtask
    task automatic count(input int c);
        logic last;
        {nc, np, nt} = '0;
        last = o_clkout_pin_o;
        repeat (c)
        begin
            @(negedge i_clk);
            nc += o_cpu_core_clock_en;
            np += o_periph_clk_en;
            nt += (o_clkout_pin_o !== last);
            last = o_clkout_pin_o;
        end
    endtask
    // ------------------------------------------------------------------
    // clock, timeout, tests
    // ------------------------------------------------------------------
    initial
    begin
        i_clk = 1'b0;
        forever #12.5 i_clk = ~i_clk;
    end
    always @(posedge i_clk)
    begin
        cyc++;
        if (cyc == 60000)
        begin
            n_mismatch++;
            end_of_test();
        end
    end
    initial
    begin
        {i_arst_n, i_trim_arst_n, i_rtc_uses_xtal, i_wdt_uses_xtal} = '0;
        {i_ctl_wr, i_ctl_src, i_ctl_dbl, i_div_wr, i_div_val} = '0;
        {i_trim_wr, i_trim_val, i_clkout_en_val, i_lp_wr, i_lp_val} = '0;
        i_user_config_byte_one = 8'h04;
        i_user_config_byte_two = 8'h00;
        i_factory_trim = 6'h2a;
        repeat (16) @(negedge i_clk);
        {i_arst_n, i_trim_arst_n} = 2'h3;
        wait_done(200);
        chk("src", 8'(o_clock_source_select), 8'h04);
        chk("dbl", 8'(o_rc_doubler_enable), 8'h00);
        chk("lp", 8'(o_low_power_clock_select), 8'h00);
        chk("trim", 8'(o_rc_trim), 8'h2a);
        chk("hold", 8'(o_cpu_hold), 8'h00);
        wr(4'h2, 8'h55);
        @(negedge i_clk);
        chk("trim", 8'(o_rc_trim), 8'h15);
        chk("oe", 8'(o_clkout_pin_oe), 8'h01);
        foreach (divs[i])
        begin
            per = 5 * (divs[i] == 8'h00 ? 1 : 2 * int'(divs[i]));
            wr(4'h4, divs[i]);
            repeat (2 * per) @(negedge i_clk);
            count(4 * per);
            chk("cpu", 8'(nc), 8'h04);
            chk("periph", 8'(np), 8'h02);
            chk("clkout", 8'(nt), 8'h04);
        end
        wr(4'h4, 8'h00);
        i_rtc_uses_xtal = 1'b1;
        repeat (2) @(negedge i_clk);
        chk("oe rtc", 8'(o_clkout_pin_oe), 8'h00);
        {i_rtc_uses_xtal, i_wdt_uses_xtal} = 2'h1;
        repeat (2) @(negedge i_clk);
        chk("oe wdt", 8'(o_clkout_pin_oe), 8'h00);
        i_wdt_uses_xtal = 1'b0;
        wr(4'h8, 8'h0d);
        chk("done", 8'(o_clock_switch_done), 8'h00);
        chk("dbl", 8'(o_rc_doubler_enable), 8'h01);
        wr(4'h8, 8'h03);
        wait_done(6000);
        chk("src", 8'(o_clock_source_select), 8'h05);
        foreach (srcs[i])
        begin
            wr(4'h8, 8'(srcs[i]));
            wait_done(9000);
            chk("src", 8'(o_clock_source_select), 8'(srcs[i]));
            repeat (2) @(negedge i_clk);
            chk("oe", 8'(o_clkout_pin_oe), 8'(srcs[i] > 3'h2));
        end
        wr(4'h1, 8'h01);
        chk("lp", 8'(o_low_power_clock_select), 8'h01);
        i_user_config_byte_one = 8'h2d;
        i_user_config_byte_two = 8'h80;
        i_arst_n = 1'b0;
        repeat (4) @(negedge i_clk);
        i_arst_n = 1'b1;
        chk("lp", 8'(o_low_power_clock_select), 8'h00);
        chk("trim", 8'(o_rc_trim), 8'h15);
        wait_done(6000);
        chk("src", 8'(o_clock_source_select), 8'h05);
        chk("dbl", 8'(o_rc_doubler_enable), 8'h01);
        i_trim_arst_n = 1'b0;
        repeat (2) @(negedge i_clk);
        i_trim_arst_n = 1'b1;
        repeat (2) @(negedge i_clk);
        chk("trim", 8'(o_rc_trim), 8'h2a);
        chk("clkout en", 8'(o_clkout_enable), 8'h00);
        wr(4'h2, 8'h15);
        chk("trim", 8'(o_rc_trim), 8'h15);
        end_of_test();
    end
endmodule // clock_gen_unit_tb_top
